//--- verilog/addr_port_pkg.sv
// shared constants and types for the dram address-channel front end
package addr_port_pkg;
   // =====================================================
   // field widths
   localparam int ADDR_W  = 33;
   localparam int ID_W    = 6;
   localparam int LEN_W   = 8;
   localparam int SIZE_W  = 3;
   localparam int BURST_W = 2;
   localparam int CACHE_W = 4;
   // =====================================================
   // burst type encodings
   localparam logic [1:0] BURST_INCR = 2'h1;
   localparam logic [1:0] BURST_WRAP = 2'h2;
   // longest burst allowed with all strobes set, as a length code
   localparam logic [7:0] ALLSTRB_MAX_LEN = 8'h0f;
   // =====================================================
   // reset values
   localparam logic       READY_RST = 1'b0;
   localparam logic [1:0] STATE_RST = 2'h1;
   // =====================================================
   typedef enum logic [1:0] {
      ST_EMPTY = 2'h1,
      ST_FULL  = 2'h2
   } slot_state_t;
endpackage

//--- verilog/addr_slot.sv
// one address channel holding slot: accept, hold, hand on
`timescale 1ns/100ps
module addr_slot #(
   parameter int WIDTH = 64
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // master side
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // controller side
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);
   import addr_port_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   initial begin
      if (WIDTH < 1) $error("addr_slot: WIDTH must be positive");
   end

   slot_state_t      state;
   slot_state_t      next_state;
   logic [WIDTH-1:0] data;
   logic [WIDTH-1:0] next_data;
   logic             live;
   logic             next_live;

   // ready only while the slot can really take a request; kept low in reset
   // and up to the first edge after it, so nothing is taken half out of reset
   assign in_ready  = live && (state == ST_EMPTY);
   assign out_valid = (state == ST_FULL);
   assign out_data  = data;

   always_comb begin
      next_state = state;
      next_data  = data;
      next_live  = 1'b1;
      unique case (state)
         ST_EMPTY: begin
            if (in_valid && live) begin
               next_state = ST_FULL;
               next_data  = in_data;
            end
         end
         ST_FULL: begin
            if (out_ready) begin
               next_state = ST_EMPTY;
            end
         end
         default: begin
            next_state = ST_EMPTY;
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= slot_state_t'(STATE_RST);
         data  <= '0;
         live  <= READY_RST;
      end else begin
         state <= next_state;
         data  <= next_data;
         live  <= next_live;
      end
   end

   chk_slot_holds: assert property (
      out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("held request changed before it was taken");
   chk_ready_empty: assert property (
      in_valid && in_ready |=> !in_ready && out_data == $past(in_data))
      else $error("slot did not capture the accepted request");
   chk_ready_reset: assert property (
      $rose(reset_n) |-> !in_ready)
      else $error("ready high on the first edge out of reset");
endmodule

//--- verilog/ddr_axi_address_port.sv
// axi4 read/write address channel front end of one dram controller port
// Contract
// - each request carries a 33-bit byte address of its first beat.
// - read burst type 01 increments, 10 wraps; beat address uses size.
// - an 8-bit length field gives the beat count of the burst.
// - a 3-bit size field gives bytes per beat.
// - a 6-bit id tags each request and its later responses.
// - address ready is high only when the request can be taken.
// - a lock input gives the atomic nature of each transfer.
// - a qos input may prioritise a request among pending ones.
// - a 4-bit memory type on writes says how they progress.
// - channels use the port's axi clock and active-low axi reset.
`timescale 1ns/100ps
module ddr_axi_address_port
   import addr_port_pkg::*;
#(
   parameter int AW = addr_port_pkg::ADDR_W
) (
   // clock and reset (axi clock, axi reset)
   input  wire logic                      clk,
   input  wire logic                      reset_n,
   // read address channel
   input  wire logic [AW-1:0]             araddr,
   input  wire logic [BURST_W-1:0]        arburst,
   input  wire logic [ID_W-1:0]           arid,
   input  wire logic [LEN_W-1:0]          arlen,
   input  wire logic [SIZE_W-1:0]         arsize,
   input  wire logic                      arvalid,
   output      logic                      arready,
   input  wire logic                      arlock,
   input  wire logic                      read_auto_precharge,
   input  wire logic                      arqos,
   // write address channel
   input  wire logic [AW-1:0]             awaddr,
   input  wire logic [BURST_W-1:0]        awburst,
   input  wire logic [ID_W-1:0]           awid,
   input  wire logic [LEN_W-1:0]          awlen,
   input  wire logic [SIZE_W-1:0]         awsize,
   input  wire logic                      awvalid,
   output      logic                      awready,
   input  wire logic                      awlock,
   input  wire logic                      write_auto_precharge,
   input  wire logic                      awqos,
   input  wire logic [CACHE_W-1:0]        awcache,
   input  wire logic                      write_all_strobes_set,
   input  wire logic                      write_coherent_bufferable_sel,
   // read command to scheduler
   output      logic                      rd_cmd_valid,
   input  wire logic                      rd_cmd_ready,
   output      logic [AW-1:0]             rd_cmd_addr,
   output      logic [AW-1:0]             rd_cmd_wrap_base,
   output      logic                      rd_cmd_wrap,
   output      logic [ID_W-1:0]           rd_cmd_id,
   output      logic [LEN_W-1:0]          rd_cmd_len,
   output      logic [SIZE_W-1:0]         rd_cmd_size,
   output      logic                      rd_cmd_lock,
   output      logic                      rd_cmd_precharge,
   output      logic                      rd_cmd_qos,
   output      logic                      rd_cmd_burst_err,
   // write command to scheduler
   output      logic                      wr_cmd_valid,
   input  wire logic                      wr_cmd_ready,
   output      logic [AW-1:0]             wr_cmd_addr,
   output      logic [BURST_W-1:0]        wr_cmd_burst,
   output      logic [ID_W-1:0]           wr_cmd_id,
   output      logic [LEN_W-1:0]          wr_cmd_len,
   output      logic [SIZE_W-1:0]         wr_cmd_size,
   output      logic                      wr_cmd_lock,
   output      logic                      wr_cmd_precharge,
   output      logic                      wr_cmd_qos,
   output      logic [CACHE_W-1:0]        wr_cmd_cache,
   output      logic                      wr_cmd_full_mask,
   output      logic                      wr_cmd_coherent,
   // qos hint: the pending request with qos set goes first
   output      logic                      prefer_write
);
   import addr_port_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   initial begin
      if (AW != ADDR_W) $error("address width must be 33");
   end

   // =====================================================
   // address arithmetic
   // wrap boundary: beats times beat size, a power of two for legal wraps
   function automatic logic [AW-1:0] wrap_base(
      input logic [AW-1:0]     addr,
      input logic [LEN_W-1:0]  len,
      input logic [SIZE_W-1:0] size
   );
      logic [AW-1:0] span;
      span = (AW'(len) + AW'(1)) << size;
      return addr & ~(span - AW'(1));
   endfunction

   // =====================================================
   // read channel
   localparam int RD_W = AW + BURST_W + ID_W + LEN_W + SIZE_W + 3;
   localparam int WR_W = AW + BURST_W + ID_W + LEN_W + SIZE_W + 3
                         + CACHE_W + 2;

   logic [RD_W-1:0] rd_in;
   logic [RD_W-1:0] rd_out;
   logic [BURST_W-1:0] rd_burst;
   logic [WR_W-1:0] wr_in;
   logic [WR_W-1:0] wr_out;
   logic            wr_allstrb;

   // all fields captured together on the accepting edge
   assign rd_in = {araddr, arburst, arid, arlen, arsize,
                   arlock, read_auto_precharge, arqos};

   addr_slot #(.WIDTH(RD_W)) u_rd_slot (
      .clk       (clk),
      .reset_n   (reset_n),
      .in_valid  (arvalid),
      .in_ready  (arready),
      .in_data   (rd_in),
      .out_valid (rd_cmd_valid),
      .out_ready (rd_cmd_ready),
      .out_data  (rd_out)
   );

   assign {rd_cmd_addr, rd_burst, rd_cmd_id, rd_cmd_len, rd_cmd_size,
           rd_cmd_lock, rd_cmd_precharge, rd_cmd_qos} = rd_out;

   // decode burst type; fixed and reserved bursts are still presented but are flagged
   assign rd_cmd_wrap      = (rd_burst == BURST_WRAP);
   assign rd_cmd_burst_err = (rd_burst != BURST_INCR)
                             && (rd_burst != BURST_WRAP);
   assign rd_cmd_wrap_base = rd_cmd_wrap
      ? wrap_base(rd_cmd_addr, rd_cmd_len, rd_cmd_size)
      : rd_cmd_addr;

   // =====================================================
   // write channel
   assign wr_in = {awaddr, awburst, awid, awlen, awsize, awlock,
                   write_auto_precharge, awqos, awcache,
                   write_all_strobes_set, write_coherent_bufferable_sel};

   addr_slot #(.WIDTH(WR_W)) u_wr_slot (
      .clk       (clk),
      .reset_n   (reset_n),
      .in_valid  (awvalid),
      .in_ready  (awready),
      .in_data   (wr_in),
      .out_valid (wr_cmd_valid),
      .out_ready (wr_cmd_ready),
      .out_data  (wr_out)
   );

   assign {wr_cmd_addr, wr_cmd_burst, wr_cmd_id, wr_cmd_len, wr_cmd_size,
           wr_cmd_lock, wr_cmd_precharge, wr_cmd_qos, wr_cmd_cache,
           wr_allstrb, wr_cmd_coherent} = wr_out;

   // longer bursts fall back to per-beat strobes, which is always safe
   assign wr_cmd_full_mask = wr_allstrb
                             && (wr_cmd_len <= ALLSTRB_MAX_LEN);

   // =====================================================
   // qos arbitration hint
   always_comb begin
      prefer_write = 1'b0;
      if (wr_cmd_valid && rd_cmd_valid) begin
         prefer_write = wr_cmd_qos && !rd_cmd_qos;
      end else begin
         prefer_write = wr_cmd_valid;
      end
   end

   // =====================================================
   // checks
   sequence rd_taken_s;
      arvalid && arready;
   endsequence
   sequence rd_presented_s;
      rd_cmd_valid && rd_cmd_id == $past(arid)
      && rd_cmd_addr == $past(araddr) && rd_cmd_len == $past(arlen);
   endsequence
   sequence wr_taken_s;
      awvalid && awready;
   endsequence

   chk_read_capture: assert property (
      rd_taken_s |=> rd_presented_s)
      else $error("accepted read not presented with its id");
   chk_write_capture: assert property (
      wr_taken_s |=> wr_cmd_valid && wr_cmd_id == $past(awid)
      && wr_cmd_cache == $past(awcache))
      else $error("accepted write not presented with its fields");
   chk_read_ready: assert property (
      rd_cmd_valid && !rd_cmd_ready |=> !arready)
      else $error("read ready high while slot full");
   chk_write_ready: assert property (
      wr_cmd_valid && !wr_cmd_ready |=> !awready)
      else $error("write ready high while slot full");
   chk_wrap_decode: assert property (
      rd_cmd_valid |-> rd_cmd_wrap == (rd_burst == 2'h2)
      && rd_cmd_burst_err == (rd_burst == 2'h0 || rd_burst == 2'h3))
      else $error("read burst type decoded wrongly");
   chk_full_mask: assert property (
      wr_cmd_full_mask |-> wr_cmd_len < 8'h10 && wr_allstrb)
      else $error("full mask on a long or unmarked write");
   chk_precharge: assert property (
      rd_taken_s |=> rd_cmd_precharge == $past(read_auto_precharge))
      else $error("read precharge flag lost");
   chk_write_precharge: assert property (
      wr_taken_s |=> wr_cmd_precharge == $past(write_auto_precharge))
      else $error("write precharge flag lost");
   chk_lock_qos: assert property (
      wr_taken_s |=> wr_cmd_lock == $past(awlock)
      && wr_cmd_qos == $past(awqos))
      else $error("write lock or qos lost");
   chk_read_lock_qos: assert property (
      rd_taken_s |=> rd_cmd_lock == $past(arlock)
      && rd_cmd_qos == $past(arqos))
      else $error("read lock or qos lost");
   chk_qos_prefer: assert property (
      rd_cmd_valid && rd_cmd_qos |-> !prefer_write)
      else $error("write preferred over a waiting qos read");
   chk_reset_idle: assert property (
      $rose(reset_n) |-> !rd_cmd_valid && !wr_cmd_valid)
      else $error("command valid right after reset");
endmodule

//--- tb/axi_addr_master.sv
// fabric-side address master model: one channel, holds a request until taken
`timescale 1ns/100ps
module axi_addr_master #(
   parameter int W = 55
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         reset_n,
   // bench side
   input  wire logic         go,
   input  wire logic [W-1:0] word,
   // channel side
   output      logic         valid,
   input  wire logic         ready,
   output      logic [W-1:0] fields
);
   // =====================================================
   // released fields show the inverse so a stale copy cannot pass
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         valid  <= 1'b0;
         fields <= '0;
      end else if (valid && ready) begin
         valid  <= 1'b0;
         fields <= ~fields;
      end else if (go && !valid) begin
         valid  <= 1'b1;
         fields <= word;
      end
   end
endmodule

//--- tb/tb_top.sv
// self-checking bench for the dram address-channel front end
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top;
   import addr_port_pkg::*;
   // =====================================================
   logic clk = 1'b0, reset_n = 1'b0, ar_go = 1'b0, aw_go = 1'b0;
   logic rd_cmd_ready = 1'b0, wr_cmd_ready = 1'b0;
   logic [54:0] ar_w = '0, ar_f;
   logic [60:0] aw_w = '0, aw_f;
   logic arvalid, arready, awvalid, awready, rd_cmd_valid, wr_cmd_valid;
   logic rd_cmd_wrap, rd_cmd_burst_err, prefer_write;
   logic [32:0] rd_cmd_wrap_base;
   logic [52:0] rd_o;
   logic [60:0] wr_o;
   int errors = 0, n_tests = 0;
   initial forever #10 clk = ~clk;
   axi_addr_master #(.W(55)) i_arm (.clk(clk), .reset_n(reset_n), .go(ar_go),
      .word(ar_w), .valid(arvalid), .ready(arready), .fields(ar_f));
   axi_addr_master #(.W(61)) i_awm (.clk(clk), .reset_n(reset_n), .go(aw_go),
      .word(aw_w), .valid(awvalid), .ready(awready), .fields(aw_f));
   ddr_axi_address_port i_dut (.clk(clk), .reset_n(reset_n),
      .araddr(ar_f[54:22]), .arburst(ar_f[21:20]), .arid(ar_f[19:14]),
      .arlen(ar_f[13:6]), .arsize(ar_f[5:3]), .arvalid(arvalid),
      .arready(arready), .arlock(ar_f[2]), .read_auto_precharge(ar_f[1]),
      .arqos(ar_f[0]), .awaddr(aw_f[60:28]), .awburst(aw_f[27:26]),
      .awid(aw_f[25:20]), .awlen(aw_f[19:12]), .awsize(aw_f[11:9]),
      .awvalid(awvalid), .awready(awready), .awlock(aw_f[8]),
      .write_auto_precharge(aw_f[7]), .awqos(aw_f[6]), .awcache(aw_f[5:2]),
      .write_all_strobes_set(aw_f[1]),
      .write_coherent_bufferable_sel(aw_f[0]),
      .rd_cmd_valid(rd_cmd_valid), .rd_cmd_ready(rd_cmd_ready),
      .rd_cmd_addr(rd_o[52:20]), .rd_cmd_wrap_base(rd_cmd_wrap_base),
      .rd_cmd_wrap(rd_cmd_wrap), .rd_cmd_id(rd_o[19:14]),
      .rd_cmd_len(rd_o[13:6]), .rd_cmd_size(rd_o[5:3]),
      .rd_cmd_lock(rd_o[2]), .rd_cmd_precharge(rd_o[1]), .rd_cmd_qos(rd_o[0]),
      .rd_cmd_burst_err(rd_cmd_burst_err), .wr_cmd_valid(wr_cmd_valid),
      .wr_cmd_ready(wr_cmd_ready), .wr_cmd_addr(wr_o[60:28]),
      .wr_cmd_burst(wr_o[27:26]), .wr_cmd_id(wr_o[25:20]),
      .wr_cmd_len(wr_o[19:12]), .wr_cmd_size(wr_o[11:9]),
      .wr_cmd_lock(wr_o[8]), .wr_cmd_precharge(wr_o[7]), .wr_cmd_qos(wr_o[6]),
      .wr_cmd_cache(wr_o[5:2]), .wr_cmd_full_mask(wr_o[1]),
      .wr_cmd_coherent(wr_o[0]), .prefer_write(prefer_write));
   // =====================================================
   // wrap window is beats times bytes per beat; base rounds down to it
   function automatic logic [32:0] wbase(logic [54:0] w);
      longint unsigned a, win;
      a   = w[54:22];
      win = (longint'(w[13:6]) + 1) * (longint'(1) << w[5:3]);
      return (w[21:20] == BURST_WRAP) ? 33'(a - a % win) : w[54:22];
   endfunction
   // fields stand and the slot refuses while a command waits
   task automatic check_cmd(input bit wr);
      if (!wr) begin
         `CHK("rd valid", 1'b1, rd_cmd_valid)
         `CHK("arready", 1'b0, arready)
         `CHK("rd fields", {ar_w[54:22], ar_w[19:0]}, rd_o)
         `CHK("rd decode", {ar_w[21:20] == BURST_WRAP, ar_w[21:20] != BURST_INCR && ar_w[21:20] != BURST_WRAP}, {rd_cmd_wrap, rd_cmd_burst_err})
         `CHK("wrap base", wbase(ar_w), rd_cmd_wrap_base)
         `CHK("prefer", aw_w[6] && !ar_w[0], prefer_write)
      end else begin
         `CHK("wr valid", 1'b1, wr_cmd_valid)
         `CHK("awready", 1'b0, awready)
         `CHK("wr fields", {aw_w[60:2], aw_w[1] && aw_w[19:12] <= ALLSTRB_MAX_LEN, aw_w[0]}, wr_o)
         `CHK("prefer", 1'b1, prefer_write)
      end
   endtask
   task automatic serve(input bit wr);
      int n;
      n = 0;
      while ((wr ? wr_cmd_valid : rd_cmd_valid) !== 1'b1 && n < 8) begin
         @(posedge clk);
         #1;
         n++;
      end
      check_cmd(wr);
      repeat ($urandom_range(3, 0)) begin
         @(posedge clk);
         #1;
         check_cmd(wr);
      end
      @(posedge clk);
      if (wr) wr_cmd_ready <= 1'b1;
      else rd_cmd_ready <= 1'b1;
      @(posedge clk);
      wr_cmd_ready <= 1'b0;
      rd_cmd_ready <= 1'b0;
      #1;
      `CHK("cmd drop", 1'b0, wr ? wr_cmd_valid : rd_cmd_valid)
      `CHK("slot free", 1'b1, wr ? awready : arready)
      `CHK("prefer after", !wr, prefer_write)
   endtask
   task automatic tally_and_finish();
      if (errors == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // =====================================================
   initial begin
      logic [1:0] rb, wb;
      logic [7:0] rl, wl;
      void'($urandom(32'h86a77958));
      repeat (7) @(posedge clk);
      #1;
      `CHK("reset ready", 2'b00, {arready, awready})
      @(posedge clk);
      reset_n <= 1'b1;
      for (int it = 0; it < 60; it++) begin
         @(posedge clk);
         rb = (it < 4) ? 2'(it) : 2'($urandom_range(3, 0));
         wb = 2'($urandom_range(2, 0));
         rl = (it == 0) ? 8'hff : 8'($urandom);
         wl = (it % 3 == 0) ? ALLSTRB_MAX_LEN : 8'($urandom);
         if (rb == BURST_WRAP) rl = (8'h2 << $urandom_range(3, 0)) - 8'h1;
         if (wb == BURST_WRAP) wl = (8'h2 << $urandom_range(3, 0)) - 8'h1;
         ar_w <= {(it == 0) ? 33'h1ffffffff : 33'({$urandom, $urandom}), rb,
                  6'($urandom), rl, 3'($urandom), 3'($urandom)};
         aw_w <= {33'({$urandom, $urandom}), wb, 6'($urandom), wl,
                  3'($urandom), 3'($urandom), 4'($urandom),
                  wl <= ALLSTRB_MAX_LEN && 1'($urandom), 1'($urandom)};
         ar_go <= 1'b1;
         aw_go <= 1'b1;
         @(posedge clk);
         ar_go <= 1'b0;
         aw_go <= 1'b0;
         serve(1'b0);
         serve(1'b1);
         // a second reset mid-run: readiness must drop and come back clean
         if (it == 30) begin
            @(posedge clk);
            reset_n <= 1'b0;
            @(posedge clk);
            #1;
            `CHK("mid rst rdy", 2'b00, {arready, awready})
            `CHK("mid rst cmd", 2'b00, {rd_cmd_valid, wr_cmd_valid})
            @(posedge clk);
            reset_n <= 1'b1;
         end
      end
      tally_and_finish();
   end
   initial begin
      #200us;
      errors++;
      tally_and_finish();
   end
endmodule
